// *** bdl_ctrl.sv ***
// Duty translation, open-loop startup with soft start, and lead angle control.
// Assumes duty_in/duty_valid come from capture logic on clk; back-EMF pins are asynchronous.
`timescale 1ns/1ps
module bdl_ctrl #(
    parameter int unsigned TICK_CYCLES = bdl_pkg::TICK_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rd_data,
    input  wire logic [7:0] duty_in,
    input  wire logic       duty_valid,
    input  wire logic       bemf_valid_pin,
    input  wire logic       bemf_zc_pin,
    output logic      [7:0] motor_duty,
    output logic      [4:0] lead_angle,
    output logic      [7:0] current_permit,
    output logic            commutate,
    output logic            closed_loop,
    output logic            input_fault,
    output logic            running
);
    logic [7:0] ack_pattern_first;
    logic [7:0] ack_pattern_second;
    logic [7:0] current_limit_config;
    logic [7:0] soft_start_config;
    logic [7:0] startup_period_config;
    logic [7:0] lead_angle_low_config;
    logic [7:0] lead_angle_high_config;
    logic [7:0] lead_ceiling_config;
    logic [7:0] duty_low_threshold;
    logic [7:0] duty_high_threshold;
    logic [7:0] action_config;
    logic [7:0] control_config;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic       zc_prev;
    logic [15:0] pre_cnt;
    logic [7:0] per_cnt;
    logic [5:0] ss_cnt;
    bdl_pkg::bdl_state_t state;
    bdl_pkg::bdl_state_t next_state;

    // Register port decode
    wire standby     = (state == bdl_pkg::ST_IDLE);
    wire we_ack0     = wr_en && (addr == bdl_pkg::OFF_ACK_FIRST);
    wire we_ack1     = wr_en && (addr == bdl_pkg::OFF_ACK_SECOND);
    wire we_cl       = wr_en && standby && (addr == bdl_pkg::OFF_CURRENT_LIM);
    wire we_ss       = wr_en && standby && (addr == bdl_pkg::OFF_SOFT_START);
    wire we_sp       = wr_en && standby && (addr == bdl_pkg::OFF_STARTUP_PER);
    wire we_lal      = wr_en && (addr == bdl_pkg::OFF_LEAD_LOW);
    wire we_lah      = wr_en && (addr == bdl_pkg::OFF_LEAD_HIGH);
    wire we_ceil     = wr_en && (addr == bdl_pkg::OFF_LEAD_CEIL);
    wire we_dlo      = wr_en && (addr == bdl_pkg::OFF_DUTY_LOW);
    wire we_dhi      = wr_en && (addr == bdl_pkg::OFF_DUTY_HIGH);
    wire we_act      = wr_en && (addr == bdl_pkg::OFF_ACTION);
    wire we_ctl      = wr_en && (addr == bdl_pkg::OFF_CONTROL);

    // Field views
    wire [1:0] low_input_action_select  = action_config[bdl_pkg::LOW_SEL_LSB +: 2];
    wire [1:0] high_input_action_select = action_config[bdl_pkg::HIGH_SEL_LSB +: 2];
    wire       run_cmd                  = control_config[bdl_pkg::RUN_BIT];
    wire [5:0] soft_start_duration      = soft_start_config[5:0];
    wire [7:0] startup_commutation_period = startup_period_config;
    wire [4:0] lead_angle_low_speed     = lead_angle_low_config[4:0];
    wire [4:0] lead_angle_high_speed    = lead_angle_high_config[4:0];
    wire [4:0] lead_angle_ceiling       = lead_ceiling_config[4:0];
    wire       bemf_ok                  = sync2[0];
    wire       zc_now                   = sync2[1];
    wire       ramp_done                = (current_permit == bdl_pkg::DUTY_FULL);
    wire [7:0] status_byte = {running, closed_loop, input_fault, ramp_done, 2'b00, state};

    wire [7:0] rd_mux =
        (addr == bdl_pkg::OFF_ACK_FIRST)   ? ack_pattern_first :
        (addr == bdl_pkg::OFF_ACK_SECOND)  ? ack_pattern_second :
        (addr == bdl_pkg::OFF_CURRENT_LIM) ? current_limit_config :
        (addr == bdl_pkg::OFF_SOFT_START)  ? soft_start_config :
        (addr == bdl_pkg::OFF_STARTUP_PER) ? startup_period_config :
        (addr == bdl_pkg::OFF_LEAD_LOW)    ? lead_angle_low_config :
        (addr == bdl_pkg::OFF_LEAD_HIGH)   ? lead_angle_high_config :
        (addr == bdl_pkg::OFF_LEAD_CEIL)   ? lead_ceiling_config :
        (addr == bdl_pkg::OFF_DUTY_LOW)    ? duty_low_threshold :
        (addr == bdl_pkg::OFF_DUTY_HIGH)   ? duty_high_threshold :
        (addr == bdl_pkg::OFF_ACTION)      ? action_config :
        (addr == bdl_pkg::OFF_CONTROL)     ? control_config :
        (addr == bdl_pkg::OFF_STATUS)      ? status_byte : 8'h00;

    // Duty translation
    wire       below     = (duty_in < duty_low_threshold);
    wire       above     = (duty_in > duty_high_threshold);
    wire [7:0] span      = duty_high_threshold - duty_low_threshold;
    wire [7:0] offset    = duty_in - duty_low_threshold;
    wire [15:0] map_num  = {8'h00, offset} * 16'h00FF;
    wire [15:0] map_quot = (span == 8'h00) ? 16'h00FF : map_num / {8'h00, span};
    // A degenerate threshold pair saturates rather than dividing by zero
    wire [7:0] map_duty  = (map_quot > 16'h00FF) ? bdl_pkg::DUTY_FULL : map_quot[7:0];
    wire [7:0] safe_duty = (low_input_action_select == bdl_pkg::LOW_SAFE) ? bdl_pkg::DUTY_SAFETY : 8'h00;
    wire [7:0] low_duty  =
        (low_input_action_select == bdl_pkg::LOW_SAFE) ? bdl_pkg::DUTY_SAFETY :
        (low_input_action_select == bdl_pkg::LOW_HOLD) ? motor_duty : 8'h00;
    wire [7:0] high_duty =
        (high_input_action_select == bdl_pkg::HIGH_HOLD) ? motor_duty :
        (high_input_action_select == bdl_pkg::HIGH_STOP) ? 8'h00 : bdl_pkg::DUTY_FULL;
    wire [7:0] next_motor_duty =
        (next_state == bdl_pkg::ST_IDLE) ? 8'h00 :
        !duty_valid ? safe_duty :
        below ? low_duty :
        above ? high_duty : map_duty;

    // Lead angle: weight 0..256 so full drive lands exactly on the high setting
    wire [9:0]         lead_weight = {2'b00, motor_duty} + {9'h000, motor_duty[7]};
    wire signed [5:0]  lead_diff   = $signed({1'b0, lead_angle_high_speed}) - $signed({1'b0, lead_angle_low_speed});
    wire signed [15:0] lead_prod   = lead_diff * $signed(lead_weight);
    wire [7:0]         lead_sum    = {3'b000, lead_angle_low_speed} + lead_prod[15:8];
    wire [4:0]         lead_raw    = lead_sum[4:0];
    wire [4:0]         next_lead   = (lead_raw > lead_angle_ceiling) ? lead_angle_ceiling : lead_raw;

    // Startup time base and commutation
    wire       tick      = !standby && (pre_cnt == 16'(TICK_CYCLES - 1));
    wire [7:0] period    = (startup_commutation_period == 8'h00) ? 8'h01 : startup_commutation_period;
    wire       per_wrap  = tick && ((per_cnt + 8'h01) >= period);
    wire       open_com  = (state == bdl_pkg::ST_OPEN) && per_wrap;
    wire       zc_edge   = zc_now && !zc_prev;
    wire       next_com  = open_com || ((state == bdl_pkg::ST_CLOSED) && zc_edge);
    wire       ss_step   = tick && !ramp_done && (ss_cnt >= soft_start_duration);

    always_comb begin
        next_state = state;
        case (state)
            bdl_pkg::ST_IDLE: begin
                if (run_cmd) begin
                    next_state = bdl_pkg::ST_OPEN;
                end
            end
            bdl_pkg::ST_OPEN: begin
                if (!run_cmd) begin
                    next_state = bdl_pkg::ST_IDLE;
                end else if (bemf_ok) begin
                    next_state = bdl_pkg::ST_CLOSED;
                end
            end
            bdl_pkg::ST_CLOSED: begin
                if (!run_cmd) begin
                    next_state = bdl_pkg::ST_IDLE;
                end else if (!bemf_ok) begin
                    // Losing back-EMF falls back to open-loop instead of stopping
                    next_state = bdl_pkg::ST_OPEN;
                end
            end
            default: begin
                next_state = bdl_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack_pattern_first  <= bdl_pkg::RST_ACK_FIRST;
            ack_pattern_second <= bdl_pkg::RST_ACK_SECOND;
        end else begin
            if (we_ack0) ack_pattern_first <= wr_data;
            if (we_ack1) ack_pattern_second <= wr_data;
        end
    end

    // Standby-only group
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            current_limit_config  <= bdl_pkg::RST_CURRENT_LIM;
            soft_start_config     <= bdl_pkg::RST_SOFT_START;
            startup_period_config <= bdl_pkg::RST_STARTUP_PER;
        end else begin
            if (we_cl) current_limit_config <= wr_data & bdl_pkg::MASK_CURRENT_LIM;
            if (we_ss) soft_start_config <= wr_data & bdl_pkg::MASK_SOFT_START;
            if (we_sp) startup_period_config <= wr_data;
        end
    end

    // Run-time adjustable group
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lead_angle_low_config  <= bdl_pkg::RST_LEAD_LOW;
            lead_angle_high_config <= bdl_pkg::RST_LEAD_HIGH;
            lead_ceiling_config    <= bdl_pkg::RST_LEAD_CEIL;
        end else begin
            if (we_lal) lead_angle_low_config <= wr_data & bdl_pkg::MASK_LEAD_LOW;
            if (we_lah) lead_angle_high_config <= wr_data & bdl_pkg::MASK_LEAD_5BIT;
            if (we_ceil) lead_ceiling_config <= wr_data & bdl_pkg::MASK_LEAD_5BIT;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            duty_low_threshold  <= bdl_pkg::RST_DUTY_LOW;
            duty_high_threshold <= bdl_pkg::RST_DUTY_HIGH;
            action_config       <= bdl_pkg::RST_ACTION;
            control_config      <= bdl_pkg::RST_CONTROL;
        end else begin
            if (we_dlo) duty_low_threshold <= wr_data;
            if (we_dhi) duty_high_threshold <= wr_data;
            if (we_act) action_config <= wr_data & bdl_pkg::MASK_ACTION;
            if (we_ctl) control_config <= wr_data & bdl_pkg::MASK_CONTROL;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= rd_en ? rd_mux : 8'h00;
        end
    end

    // Back-EMF pins are asynchronous to clk
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync1   <= 2'b00;
            sync2   <= 2'b00;
            zc_prev <= 1'b0;
        end else begin
            sync1   <= {bemf_zc_pin, bemf_valid_pin};
            sync2   <= sync1;
            zc_prev <= zc_now;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= bdl_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pre_cnt <= 16'h0000;
            per_cnt <= 8'h00;
        end else if (standby || ((state != bdl_pkg::ST_OPEN) && tick)) begin
            pre_cnt <= tick ? 16'h0000 : (standby ? 16'h0000 : pre_cnt + 16'h0001);
            per_cnt <= 8'h00;
        end else begin
            pre_cnt <= tick ? 16'h0000 : pre_cnt + 16'h0001;
            per_cnt <= per_wrap ? 8'h00 : (tick ? per_cnt + 8'h01 : per_cnt);
        end
    end

    // Longer duration means more ticks per permit step, so a slower ramp
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ss_cnt         <= 6'h00;
            current_permit <= 8'h00;
        end else if (next_state == bdl_pkg::ST_IDLE) begin
            ss_cnt         <= 6'h00;
            current_permit <= 8'h00;
        end else if (ss_step) begin
            ss_cnt         <= 6'h00;
            current_permit <= current_permit + 8'h01;
        end else if (tick && !ramp_done) begin
            ss_cnt         <= ss_cnt + 6'h01;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            motor_duty  <= 8'h00;
            lead_angle  <= 5'h00;
            commutate   <= 1'b0;
            closed_loop <= 1'b0;
            input_fault <= 1'b0;
            running     <= 1'b0;
        end else begin
            motor_duty  <= next_motor_duty;
            lead_angle  <= next_lead;
            commutate   <= next_com;
            closed_loop <= (next_state == bdl_pkg::ST_CLOSED);
            input_fault <= !duty_valid;
            running     <= (next_state != bdl_pkg::ST_IDLE);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_low_stop_action: assert property (running && run_cmd && duty_valid && below &&
        low_input_action_select == bdl_pkg::LOW_STOP |=> motor_duty == 8'h00)
        else $error("low input stop action not applied");
    a_mid_top_map: assert property (running && run_cmd && duty_valid && !below &&
        duty_in == duty_high_threshold |=> motor_duty == bdl_pkg::DUTY_FULL)
        else $error("high threshold input did not give full duty");
    a_high_stop_action: assert property (running && run_cmd && duty_valid && above &&
        high_input_action_select == bdl_pkg::HIGH_STOP |=> motor_duty == 8'h00)
        else $error("high input stop action not applied");
    a_closed_needs_bemf: assert property ($rose(closed_loop) |-> $past(bemf_ok))
        else $error("closed loop entered without valid back-EMF");
    a_start_open_first: assert property ($rose(running) |-> !closed_loop)
        else $error("start did not begin open-loop");
    a_open_com_spacing: assert property (commutate && !closed_loop |=> !commutate [*2])
        else $error("open-loop commutations too close");
    a_permit_ramp_step: assert property (running && $past(running) |->
        current_permit == $past(current_permit) || current_permit == $past(current_permit) + 8'h01)
        else $error("current permit jumped");
    a_permit_idle_zero: assert property (!running |-> current_permit == 8'h00)
        else $error("current permit not zero in standby");
    // Settings are taken as they stood at the launching edge, so a write in that cycle cannot trip these
    a_lead_zero_duty: assert property (motor_duty == 8'h00 |=> lead_angle ==
        (($past(lead_angle_low_speed) > $past(lead_angle_ceiling)) ? $past(lead_angle_ceiling) :
        $past(lead_angle_low_speed)))
        else $error("lead angle at zero drive not the low setting");
    a_lead_ceiling: assert property (1'b1 |=> lead_angle <= $past(lead_angle_ceiling))
        else $error("lead angle above ceiling");
    a_standby_lock: assert property (running && wr_en && addr == bdl_pkg::OFF_SOFT_START |=>
        $stable(soft_start_config))
        else $error("standby-only field changed while running");
    a_fault_safety: assert property (running && run_cmd && !duty_valid &&
        low_input_action_select == bdl_pkg::LOW_SAFE |=> motor_duty == bdl_pkg::DUTY_SAFETY && input_fault)
        else $error("input fault did not select safety duty");
endmodule

// *** bdl_motor_model.sv ***
// Behavioural motor and power stage, seen through the back-EMF comparators.
// Assumes the controller's commutate pulse and running level on the same clk.
`timescale 1ns/1ps
module bdl_motor_model #(
    parameter int SPIN_COMMS = 3,
    parameter int ZC_CYCLES  = 10
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic commutate,
    input  wire logic running,
    input  wire logic spin_ok,
    output logic      bemf_valid_pin,
    output logic      bemf_zc_pin
);
    int comms;
    int zc_cnt;
    // A stalled rotor (spin_ok low) never gives usable back-EMF, so the bench can hold open loop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            comms <= 0;
            zc_cnt <= 0;
            bemf_valid_pin <= 1'b0;
            bemf_zc_pin <= 1'b0;
        end else if (!running || !spin_ok) begin
            comms <= 0;
            zc_cnt <= 0;
            bemf_valid_pin <= 1'b0;
            bemf_zc_pin <= 1'b0;
        end else begin
            if (commutate && comms < SPIN_COMMS)
                comms <= comms + 1;
            bemf_valid_pin <= (comms >= SPIN_COMMS);
            zc_cnt <= (zc_cnt == ZC_CYCLES - 1) ? 0 : zc_cnt + 1;
            bemf_zc_pin <= (comms >= SPIN_COMMS) && (zc_cnt < ZC_CYCLES / 2);
        end
    end
endmodule

// *** bdl_pkg.sv ***
// Constants, field layout and state encoding of the duty, startup and lead angle controller.
// Assumes a 100 MHz system clock and a byte-wide register port.
package bdl_pkg;
    // Register offsets
    localparam logic [7:0] OFF_ACK_FIRST    = 8'h00;
    localparam logic [7:0] OFF_ACK_SECOND   = 8'h01;
    localparam logic [7:0] OFF_CURRENT_LIM  = 8'h02;
    localparam logic [7:0] OFF_SOFT_START   = 8'h03;
    localparam logic [7:0] OFF_STARTUP_PER  = 8'h04;
    localparam logic [7:0] OFF_LEAD_LOW     = 8'h05;
    localparam logic [7:0] OFF_LEAD_HIGH    = 8'h06;
    localparam logic [7:0] OFF_LEAD_CEIL    = 8'h07;
    localparam logic [7:0] OFF_DUTY_LOW     = 8'h08;
    localparam logic [7:0] OFF_DUTY_HIGH    = 8'h09;
    localparam logic [7:0] OFF_ACTION       = 8'h0A;
    localparam logic [7:0] OFF_CONTROL      = 8'h0B;
    localparam logic [7:0] OFF_STATUS       = 8'h0C;

    // Writable bit masks; masked bits read as zero
    localparam logic [7:0] MASK_CURRENT_LIM = 8'h3F;
    localparam logic [7:0] MASK_SOFT_START  = 8'h3F;
    localparam logic [7:0] MASK_LEAD_LOW    = 8'h9F;
    localparam logic [7:0] MASK_LEAD_5BIT   = 8'h1F;
    localparam logic [7:0] MASK_ACTION      = 8'h0F;
    localparam logic [7:0] MASK_CONTROL     = 8'h01;

    // Field positions
    localparam int LOW_SEL_LSB  = 0;
    localparam int HIGH_SEL_LSB = 2;
    localparam int RUN_BIT      = 0;

    // Reset values
    localparam logic [7:0] RST_ACK_FIRST    = 8'h55;
    localparam logic [7:0] RST_ACK_SECOND   = 8'hAA;
    localparam logic [7:0] RST_CURRENT_LIM  = 8'h20;
    localparam logic [7:0] RST_SOFT_START   = 8'h08;
    localparam logic [7:0] RST_STARTUP_PER  = 8'h10;
    localparam logic [7:0] RST_LEAD_LOW     = 8'h00;
    localparam logic [7:0] RST_LEAD_HIGH    = 8'h00;
    localparam logic [7:0] RST_LEAD_CEIL    = 8'h1F;
    localparam logic [7:0] RST_DUTY_LOW     = 8'h10;
    localparam logic [7:0] RST_DUTY_HIGH    = 8'hF0;
    localparam logic [7:0] RST_ACTION       = 8'h01;
    localparam logic [7:0] RST_CONTROL      = 8'h00;

    // Out-of-range actions
    localparam logic [1:0] LOW_STOP  = 2'h0;
    localparam logic [1:0] LOW_SAFE  = 2'h1;
    localparam logic [1:0] LOW_HOLD  = 2'h2;
    localparam logic [1:0] HIGH_FULL = 2'h0;
    localparam logic [1:0] HIGH_HOLD = 2'h1;
    localparam logic [1:0] HIGH_STOP = 2'h2;

    localparam logic [7:0] DUTY_FULL   = 8'hFF;
    localparam logic [7:0] DUTY_SAFETY = 8'h40;

    // Startup time base
    localparam int CLK_MHZ     = 100;
    localparam int TICK_US     = 100;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_OPEN   = 2'b01,
        ST_CLOSED = 2'b10
    } bdl_state_t;
endpackage

// *** bldc_duty_startup_lead_ctrl_bench.sv ***
// Self-checking bench for the duty, startup and lead angle controller.
// Assumes bdl_pkg and bdl_motor_model are compiled first; a short tick keeps runs brief.
`timescale 1ns/1ps
module bldc_duty_startup_lead_ctrl_bench;
    localparam int TICK = 4;
    localparam logic [7:0] RST [0:11] = '{bdl_pkg::RST_ACK_FIRST, bdl_pkg::RST_ACK_SECOND, bdl_pkg::RST_CURRENT_LIM,
        bdl_pkg::RST_SOFT_START, bdl_pkg::RST_STARTUP_PER, bdl_pkg::RST_LEAD_LOW, bdl_pkg::RST_LEAD_HIGH,
        bdl_pkg::RST_LEAD_CEIL, bdl_pkg::RST_DUTY_LOW, bdl_pkg::RST_DUTY_HIGH, bdl_pkg::RST_ACTION, bdl_pkg::RST_CONTROL};
    logic        clk = 1'b0, resetn = 1'b0, wr_en = 1'b0, rd_en = 1'b0, duty_valid = 1'b1, spin_ok = 1'b0;
    logic [7:0]  addr = 8'h00, wr_data = 8'h00, duty_in = 8'h00;
    logic [7:0]  rd_data, motor_duty, current_permit, got, lo, hi, act, ll, lh, cl, prev;
    logic [4:0]  lead_angle;
    logic        commutate, closed_loop, input_fault, running, bemf_valid_pin, bemf_zc_pin;
    logic [31:0] rnd = 32'h6F81;
    int          err_total = 0;
    int          n_tests = 0;
    int          n;

    bdl_ctrl #(.TICK_CYCLES(TICK)) i_bdl_ctrl (.clk(clk), .resetn(resetn), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .duty_in(duty_in), .duty_valid(duty_valid),
        .bemf_valid_pin(bemf_valid_pin), .bemf_zc_pin(bemf_zc_pin), .motor_duty(motor_duty),
        .lead_angle(lead_angle), .current_permit(current_permit), .commutate(commutate),
        .closed_loop(closed_loop), .input_fault(input_fault), .running(running));
    bdl_motor_model i_bdl_motor_model (.clk(clk), .resetn(resetn), .commutate(commutate), .running(running),
        .spin_ok(spin_ok), .bemf_valid_pin(bemf_valid_pin), .bemf_zc_pin(bemf_zc_pin));

    always #5 clk = ~clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] mask(input int a);
        case (a)
            2: return bdl_pkg::MASK_CURRENT_LIM;
            3: return bdl_pkg::MASK_SOFT_START;
            5: return bdl_pkg::MASK_LEAD_LOW;
            6, 7: return bdl_pkg::MASK_LEAD_5BIT;
            10: return bdl_pkg::MASK_ACTION;
            default: return 8'hFF;
        endcase
    endfunction
    function automatic logic [7:0] exp_duty(input logic [7:0] d, input logic v, input logic [3:0] a);
        if (!v || d < lo)
            return (a[1:0] == bdl_pkg::LOW_SAFE) ? bdl_pkg::DUTY_SAFETY : (v && a[1:0] == bdl_pkg::LOW_HOLD) ? prev : 8'h00;
        if (d > hi)
            return (a[3:2] == bdl_pkg::HIGH_HOLD) ? prev : (a[3:2] == bdl_pkg::HIGH_STOP) ? 8'h00 : bdl_pkg::DUTY_FULL;
        if (hi <= lo)
            return bdl_pkg::DUTY_FULL;
        return 8'((int'(d - lo) * 255) / int'(hi - lo));
    endfunction
    function automatic logic [4:0] exp_lead(input logic [7:0] m);
        int t;
        int r;
        t = (int'(lh[4:0]) - int'(ll[4:0])) * (int'(m) + int'(m[7]));
        r = int'(ll[4:0]) + ((t >= 0) ? t / 256 : -((255 - t) / 256));
        return (r > int'(cl[4:0])) ? cl[4:0] : 5'(r);
    endfunction

    task automatic summarize();
        if (err_total == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic guard(input int c, input int lim);
        if (c >= lim) begin
            err_total++;
            $display("[FAIL] %0t wait ran out", $time);
            summarize();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        got = rd_data;
    endtask
    task automatic until_comm(output int c);
        c = 0;
        do begin
            @(posedge clk);
            #1;
            c++;
        end while (commutate !== 1'b1 && c < 600);
        guard(c, 600);
    endtask
    // Starts right after the run write lands; the ramp must begin at zero and slow with a longer duration
    task automatic start_run(input logic [7:0] dur, input logic [7:0] per);
        int c;
        wr(bdl_pkg::OFF_SOFT_START, dur);
        wr(bdl_pkg::OFF_STARTUP_PER, per);
        wr(bdl_pkg::OFF_CONTROL, 8'h01);
        @(posedge clk);
        #1;
        chk({7'b0, running}, 8'h01);
        chk(current_permit, 8'h00);
        c = 0;
        while (current_permit < 8'h08 && c < 2000) begin
            @(posedge clk);
            #1;
            c++;
        end
        guard(c, 2000);
        chk({7'b0, c >= 7 * (dur + 1) * TICK && c <= 9 * (dur + 1) * TICK}, 8'h01);
        until_comm(n);
        until_comm(n);
        chk(8'(n), 8'((per == 0 ? 1 : per) * TICK));
    endtask
    task automatic stop_run();
        wr(bdl_pkg::OFF_CONTROL, 8'h00);
        @(posedge clk);
        #1;
        chk(motor_duty, 8'h00);
        chk(current_permit, 8'h00);
    endtask
    // Full duty is allowed here: the model motor has no top speed
    task automatic settle(input logic [7:0] d, input logic v);
        logic [7:0] e;
        @(posedge clk);
        duty_in <= d;
        duty_valid <= v;
        repeat (3) @(posedge clk);
        #1;
        e = exp_duty(d, v, act[3:0]);
        chk(motor_duty, e);
        chk({3'b0, lead_angle}, {3'b0, exp_lead(e)});
        chk({7'b0, input_fault}, {7'b0, !v});
        prev = e;
    endtask

    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        for (int a = 0; a < 12; a++) begin
            rd(8'(a));
            chk(got, RST[a]);
        end
        rd(8'h0D);
        chk(got, 8'h00);
        for (int a = 0; a < 11; a++) begin
            wr(8'(a), ~RST[a]);
            rd(8'(a));
            chk(got, ~RST[a] & mask(a));
        end
        wr(bdl_pkg::OFF_STATUS, 8'hFF);
        rd(bdl_pkg::OFF_STATUS);
        chk(got & 8'hEF, 8'h00);
        start_run(8'h02, 8'h03);
        chk({7'b0, closed_loop}, 8'h00);
        wr(bdl_pkg::OFF_STARTUP_PER, 8'h07);
        rd(bdl_pkg::OFF_STARTUP_PER);
        chk(got, 8'h03);
        spin_ok <= 1'b1;
        n = 0;
        while (closed_loop !== 1'b1 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
        guard(n, 400);
        until_comm(n);
        until_comm(n);
        chk(8'(n), 8'd10);
        rd(bdl_pkg::OFF_STATUS);
        chk(got & 8'hEF, 8'hC2);
        spin_ok <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        chk({7'b0, closed_loop}, 8'h00);
        for (int i = 0; i < 48; i++) begin
            rnd = lfsr(rnd);
            lo = rnd[7:0] < rnd[15:8] ? rnd[7:0] : rnd[15:8];
            hi = rnd[7:0] < rnd[15:8] ? rnd[15:8] : rnd[7:0];
            act = 8'(i % 16);
            ll = {3'b0, rnd[20:16]};
            lh = {3'b0, rnd[25:21]};
            cl = (i % 5 == 0) ? 8'h1F : {3'b0, rnd[30:26]};
            wr(bdl_pkg::OFF_DUTY_LOW, lo);
            wr(bdl_pkg::OFF_DUTY_HIGH, hi);
            wr(bdl_pkg::OFF_ACTION, act);
            wr(bdl_pkg::OFF_LEAD_LOW, ll);
            wr(bdl_pkg::OFF_LEAD_HIGH, lh);
            wr(bdl_pkg::OFF_LEAD_CEIL, cl);
            settle(lo, 1'b1);
            rnd = lfsr(rnd);
            settle((i % 3 == 0) ? hi : rnd[7:0], i % 6 != 5);
        end
        stop_run();
        start_run(8'h00, 8'h00);
        stop_run();
        summarize();
    end
endmodule
